/* File: src/mst_pkg.sv */
/*
  Package for the microstep waveform generator and driver register set.
  Holds register indices, field positions, reset values and shared types.
  Assumes a 10 MHz device clock and APB access with byte address = 4 x index.
*/
package mst_pkg;

  // Register indices; the APB byte address is four times the index
  localparam logic [9:0] MST_I_TABLE0   = 10'h060; // Wave table word 0
  localparam logic [9:0] MST_I_TABLE7   = 10'h067; // Wave table word 7
  localparam logic [9:0] MST_I_SEGSEL   = 10'h068; // wave_segment_select
  localparam logic [9:0] MST_I_START    = 10'h069; // wave_start_values
  localparam logic [9:0] MST_I_POS      = 10'h06a; // microstep_position
  localparam logic [9:0] MST_I_CUR      = 10'h06b; // phase_currents_actual
  localparam logic [9:0] MST_I_CHOP     = 10'h06c; // chopper_config
  localparam logic [9:0] MST_I_CSCALE   = 10'h06d; // current_scaling_config
  localparam logic [9:0] MST_I_COMM     = 10'h06e; // commutation_control
  localparam logic [9:0] MST_I_DSTAT    = 10'h06f; // driver_status
  localparam logic [9:0] MST_I_VPWM     = 10'h070; // voltage_pwm_config
  localparam logic [9:0] MST_I_REGRES   = 10'h071; // amplitude_regulator_result
  localparam logic [9:0] MST_I_AUTO     = 10'h072; // auto_tuned_pwm_values
  localparam logic [9:0] MST_I_STEPCFG  = 10'h07a; // step_config

  // Field positions
  localparam int MST_F_HI_LSB    = 16; // Upper field of split registers
  localparam int MST_F_RES_MSB   = 3;  // step_config resolution exponent
  localparam int MST_F_FSHI      = 8;  // step_config high-velocity step-loss enable
  localparam int MST_F_SG_SHIFT  = 4;  // Step-loss field counts 16 clocks

  // Reset values
  localparam logic [31:0] MST_RST_CHOP  = 32'h1041_0150;
  localparam logic [31:0] MST_RST_VPWM  = 32'hc40c_001e;
  localparam logic [7:0]  MST_RST_SIN   = 8'h00;
  localparam logic [7:0]  MST_RST_SIN90 = 8'hf7;
  localparam logic [3:0]  MST_RST_RES   = 4'h0;
  // Default table: 248-amplitude sine, differentially coded
  localparam logic [7:0][31:0] MST_RST_TABLE = {
    32'h0040_4222, 32'h4929_5556, 32'hb5bb_777d, 32'hfbff_ffff,
    32'h1010_4222, 32'h2449_2929, 32'h4a95_54aa, 32'haaaa_b554};
  localparam logic [31:0] MST_RST_SEGSEL = 32'hffff_8056;

  // Timing
  localparam int MST_CLK_NS  = 100; // Clock period
  localparam int MST_MAX_RES = 8;   // Largest step increment exponent
  localparam logic [9:0] MST_B_OFS = 10'h100; // Phase B table offset

  // Segment definition layout
  typedef struct packed {
    logic [7:0] x3; // Segment 3 start
    logic [7:0] x2; // Segment 2 start
    logic [7:0] x1; // Segment 1 start
    logic [1:0] w3; // Width codes per segment
    logic [1:0] w2;
    logic [1:0] w1;
    logic [1:0] w0;
  } mst_seg_t;

  // Commutation limits as held in commutation_control
  typedef struct packed {
    logic [7:0] step_loss_on_limit;   // Times 16 clocks, 0 = off
    logic [5:0] pad;
    logic [9:0] commutation_on_limit; // Times one clock
  } mst_comm_t;

endpackage : mst_pkg

/* File: src/mst_wave_regs.sv */
/*
  Microstep waveform generator with its driver register set on APB.
  Assumes a 10 MHz clock, step/dir/enable pins from outside the clock
  domain, and regulator and velocity inputs from logic on the same clock.
*/
// Our own choice: register access over APB.
// Summary of operation
// - 256 one-bit delta entries in eight words
// - Bit and width code decode to increment
// - Four segments, each with own width
// - Segment borders at X1, X2, X3
// - Start values for entry 0 and 256
// - Reload both currents when counter hits zero
// - Read-only 10-bit microstep counter
// - Phase B runs 256 entries ahead
// - Read signed 9-bit phase A and B
// - Commutation on-time limit in clocks
// - Step-loss on-time limit, zero disables
// - Commutation enabled by pin or velocity
// - Step-loss kept above high velocity threshold
// - Duty cycle readable and scales currents
// - Signed regulator offset readable
// - Auto offset readable in low byte
// - Auto gradient readable in bits 23:16
`timescale 1ns/1ps
`default_nettype none

module mst_wave_regs
  import mst_pkg::*;
(
  input  wire logic        i_mclk,            // Device clock
  input  wire logic        i_rst,             // Asynchronous reset
  input  wire logic        i_psel,            // APB select
  input  wire logic        i_penable,         // APB enable
  input  wire logic        i_pwrite,          // APB direction
  input  wire logic [11:0] i_paddr,           // APB byte address
  input  wire logic [31:0] i_pwdata,          // APB write data
  output logic      [31:0] o_prdata,          // APB read data
  output logic             o_pready,          // APB ready
  output logic             o_pslverr,         // APB error
  input  wire logic        i_step_pin,        // Step pin
  input  wire logic        i_dir_pin,         // Direction pin
  input  wire logic        i_commutation_enable_pin, // Commutation pin
  input  wire logic        i_above_commutation_velocity_threshold,    // Velocity over commutation threshold
  input  wire logic        i_above_high_velocity_threshold,     // Velocity over high threshold
  input  wire logic        i_pwm_on,          // Bridge PWM on phase
  input  wire logic [7:0]  i_duty_cycle_actual, // Regulator duty cycle
  input  wire logic [8:0]  i_duty_offset,     // Regulator signed offset
  input  wire logic [7:0]  i_auto_offset,     // Auto offset value
  input  wire logic [7:0]  i_auto_gradient_value, // Auto gradient value
  input  wire logic [31:0] i_driver_status,   // Status word from driver
  output logic      [8:0]  o_phase_a_current, // Table current A
  output logic      [8:0]  o_phase_b_current, // Table current B
  output logic      [8:0]  o_coil_a_scaled,   // A scaled by duty
  output logic      [8:0]  o_coil_b_scaled,   // B scaled by duty
  output logic             o_comm_active,     // Commutation mode on
  output logic             o_steploss_active, // Step-loss check on
  output logic             o_comm_limit_hit,  // On time reached limit
  output logic             o_step_loss,       // Step loss detected
  output logic      [31:0] o_chopper_config,  // Chopper setup
  output logic      [24:0] o_current_scaling_config, // Current scaling setup
  output logic      [31:0] o_voltage_pwm_config // Voltage PWM setup
);

  // Assertions sample on the device clock and rest during reset
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  // Register storage
  logic [7:0][31:0] table_r;    // Wave table words
  mst_seg_t         seg_r;      // Segment definition
  logic [7:0]       sin_r;      // Start value, entry 0
  logic [7:0]       sin90_r;    // Start value, entry 256
  mst_comm_t        comm_r;     // Commutation limits
  logic [3:0]       res_r;      // Step increment exponent
  logic             fshi_r;     // Step loss above high velocity
  logic [31:0]      chop_r;     // chopper_config
  logic [24:0]      cscale_r;   // current_scaling_config
  logic [31:0]      vpwm_r;     // voltage_pwm_config
  // Waveform state
  logic [9:0]        pos_r;     // Microstep counter
  logic [9:0]        pos_nxt;
  logic signed [11:0] pend_r;   // Entries still to walk
  logic signed [11:0] pend_nxt;
  logic signed [9:0] mag_r [2]; // Magnitude per phase
  logic [8:0]        cur_r [2]; // Signed current per phase
  // Pin synchronisers and filtered levels
  logic [2:0] step_s_r;
  logic [2:0] dir_s_r;
  logic [2:0] den_s_r;
  logic       step_f_r;
  logic       dir_f_r;
  logic       den_f_r;
  logic       step_ev;          // Filtered rising step edge
  // APB decode
  logic [9:0] idx;              // Register index
  logic       mapped;           // Index is one of ours
  logic       acc;              // Access phase
  logic       wr;               // Write takes effect
  logic [31:0] rmux;            // Read value
  logic [12:0] ontime_r;        // Clocks in current PWM on phase

  // Write strobes and APB decode
  assign idx      = i_paddr[11:2];
  assign acc      = i_psel & i_penable;
  assign mapped   = (i_paddr[1:0] == 2'b00) &&
                    ((idx >= MST_I_TABLE0 && idx <= MST_I_AUTO) ||
                     idx == MST_I_STEPCFG);
  assign wr       = acc & i_pwrite & mapped;
  assign o_pready = 1'b1;       // Never wait
  assign o_pslverr = acc & ~mapped;

  // Read multiplexer; write-only registers read as zero
  always_comb begin
    rmux = 32'h0000_0000;
    case (idx)
      MST_I_POS:    rmux = {22'h000000, pos_r};
      MST_I_CUR:    rmux = {7'h00, cur_r[1], 7'h00, cur_r[0]};
      MST_I_CHOP:   rmux = chop_r;
      MST_I_DSTAT:  rmux = i_driver_status;
      MST_I_REGRES: rmux = {7'h00, i_duty_offset, 8'h00, i_duty_cycle_actual};
      MST_I_AUTO:   rmux = {8'h00, i_auto_gradient_value, 8'h00, i_auto_offset};
      MST_I_STEPCFG: rmux = {23'h000000, fshi_r, 4'h0, res_r};
      default:      rmux = 32'h0000_0000;
    endcase
  end

  // Read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_psel && !i_penable) begin
      o_prdata <= mapped ? rmux : 32'h0000_0000;
    end
  end

  // Wave table and segment definition, default sine after reset
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      table_r <= MST_RST_TABLE;
      seg_r   <= MST_RST_SEGSEL;
    end else if (wr) begin
      if (idx <= MST_I_TABLE7) begin
        table_r[idx[2:0]] <= i_pwdata;
      end
      if (idx == MST_I_SEGSEL) begin
        seg_r <= i_pwdata;
      end
    end
  end

  // Start values; written mid-wave they act only at the next zero pass
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sin_r   <= MST_RST_SIN;
      sin90_r <= MST_RST_SIN90;
    end else if (wr && idx == MST_I_START) begin
      sin_r   <= i_pwdata[7:0];
      sin90_r <= i_pwdata[MST_F_HI_LSB +: 8];
    end
  end

  // Driver configuration registers
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      chop_r   <= MST_RST_CHOP;
      cscale_r <= 25'h0000000;
      comm_r   <= '0;
      vpwm_r   <= MST_RST_VPWM;
      res_r    <= MST_RST_RES;
      fshi_r   <= 1'b0;
    end else if (wr) begin
      case (idx)
        MST_I_CHOP:    chop_r   <= i_pwdata;
        MST_I_CSCALE:  cscale_r <= i_pwdata[24:0];
        MST_I_COMM:    comm_r   <= {i_pwdata[23:16], 6'h00, i_pwdata[9:0]};
        MST_I_VPWM:    vpwm_r   <= i_pwdata;
        MST_I_STEPCFG: begin
          res_r  <= i_pwdata[MST_F_RES_MSB:0];
          fshi_r <= i_pwdata[MST_F_FSHI];
        end
        default: ;
      endcase
    end
  end

  assign o_chopper_config         = chop_r;
  assign o_current_scaling_config = cscale_r;
  assign o_voltage_pwm_config     = vpwm_r;

  // Pin synchronisers; a level counts once stages two and three agree
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      step_s_r <= 3'b000;
      dir_s_r  <= 3'b000;
      den_s_r  <= 3'b000;
      step_f_r <= 1'b0;
      dir_f_r  <= 1'b0;
      den_f_r  <= 1'b0;
    end else begin
      step_s_r <= {step_s_r[1:0], i_step_pin};
      dir_s_r  <= {dir_s_r[1:0], i_dir_pin};
      den_s_r  <= {den_s_r[1:0], i_commutation_enable_pin};
      if (step_s_r[1] == step_s_r[2]) begin
        step_f_r <= step_s_r[2];
      end
      if (dir_s_r[1] == dir_s_r[2]) begin
        dir_f_r <= dir_s_r[2];
      end
      if (den_s_r[1] == den_s_r[2]) begin
        den_f_r <= den_s_r[2];
      end
    end
  end

  assign step_ev = (step_s_r[1] == step_s_r[2]) & step_s_r[2] & ~step_f_r;

  // Delta of one table entry, decoded by its segment width code
  function automatic logic signed [2:0] mst_delta(input logic [7:0] j,
                                                  input logic [7:0][31:0] blank_time,
                                                  input mst_seg_t s);
    logic [1:0] w;
    w = (j >= s.x3) ? s.w3 :
        (j >= s.x2) ? s.w2 :
        (j >= s.x1) ? s.w1 : s.w0;
    // Bit 0 gives code minus one, bit 1 gives code
    return $signed({1'b0, w}) - 3'sd1 + $signed({2'b00, blank_time[j[7:5]][j[4:0]]});
  endfunction : mst_delta

  // Pending walk: each step adds or subtracts 2 to the power of the resolution (at most 8), one entry moves per clock
  always_comb begin
    logic [3:0] r;
    r = (res_r > 4'(MST_MAX_RES)) ? 4'(MST_MAX_RES) : res_r;
    pend_nxt = pend_r;
    pos_nxt  = pos_r;
    if (pend_r > 0) begin
      pos_nxt  = pos_r + 10'h001;
      pend_nxt = pend_r - 12'sd1;
    end else if (pend_r < 0) begin
      pos_nxt  = pos_r - 10'h001;
      pend_nxt = pend_r + 12'sd1;
    end
    if (step_ev) begin
      if (dir_f_r) begin
        pend_nxt = pend_nxt - $signed(12'(1) << r);
      end else begin
        pend_nxt = pend_nxt + $signed(12'(1) << r);
      end
    end
  end

  // Counter and pending walk
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pos_r  <= 10'h000;
      pend_r <= 12'sh000;
    end else begin
      pos_r  <= pos_nxt;
      pend_r <= pend_nxt;
    end
  end

  // One engine per phase; phase B runs at counter plus 256
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_phase
      logic [9:0]        p;     // Phase table position
      logic [8:0]        lo;    // Lower end of the crossed transition
      logic [7:0]        j;     // Quarter index, mirrored past 255
      logic signed [9:0] d;     // Signed magnitude change
      logic              up;    // Moving upward
      assign p  = pos_r + (g == 1 ? MST_B_OFS : 10'h000);
      assign up = (pend_r > 0);
      assign lo = up ? p[8:0] : p[8:0] - 9'h001;
      // Second half of each half wave reads the quarter backwards
      assign j  = lo[8] ? ~lo[7:0] : lo[7:0];
      assign d  = 10'(mst_delta(j, table_r, seg_r));

      // Magnitude tracks the walk; a zero pass reloads the start value
      always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
          mag_r[g] <= (g == 1) ? $signed({2'b00, MST_RST_SIN90}) : 10'sh000;
        end else if (pos_nxt != pos_r && pos_nxt == 10'h000) begin
          mag_r[g] <= $signed({2'b00, (g == 1) ? sin90_r : sin_r});
        end else if (pos_nxt != pos_r) begin
          mag_r[g] <= (up ^ lo[8]) ? mag_r[g] + d : mag_r[g] - d;
        end
      end

      // Sign follows the half wave the phase sits in
      always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
          cur_r[g] <= 9'h000;
        end else begin
          cur_r[g] <= p[9] ? 9'(-mag_r[g]) : 9'(mag_r[g]);
        end
      end
    end
  endgenerate

  assign o_phase_a_current = cur_r[0];
  assign o_phase_b_current = cur_r[1];

  // Scale by duty; operands widened to 18 bits so the product never wraps
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_coil_a_scaled <= 9'h000;
      o_coil_b_scaled <= 9'h000;
    end else begin
      o_coil_a_scaled <= 9'(($signed({{9{cur_r[0][8]}}, cur_r[0]}) *
                            $signed({10'h000, i_duty_cycle_actual})) >>> 8);
      o_coil_b_scaled <= 9'(($signed({{9{cur_r[1][8]}}, cur_r[1]}) *
                            $signed({10'h000, i_duty_cycle_actual})) >>> 8);
    end
  end

  // Mode enables; step loss can run at high speed without commutation
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_comm_active     <= 1'b0;
      o_steploss_active <= 1'b0;
    end else begin
      o_comm_active     <= den_f_r | i_above_commutation_velocity_threshold;
      o_steploss_active <= (comm_r.step_loss_on_limit != 8'h00) &&
                           ((den_f_r | i_above_commutation_velocity_threshold) ||
                            (fshi_r & i_above_high_velocity_threshold));
    end
  end

  // On-time timer, saturating so a stuck on phase stays flagged once
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ontime_r <= 13'h0000;
    end else if (!i_pwm_on) begin
      ontime_r <= 13'h0000;
    end else if (ontime_r != 13'h1fff) begin
      ontime_r <= ontime_r + 13'h0001;
    end
  end

  // Limit pulses: commutation limit in clocks, step loss in 16 clocks
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_comm_limit_hit <= 1'b0;
      o_step_loss      <= 1'b0;
    end else begin
      o_comm_limit_hit <= i_pwm_on && o_comm_active &&
                          comm_r.commutation_on_limit != 10'h000 &&
                          ontime_r == {3'b000, comm_r.commutation_on_limit};
      o_step_loss      <= i_pwm_on && o_steploss_active &&
                          ontime_r == 13'({comm_r.step_loss_on_limit, 4'h0});
    end
  end

  // Checks; the step-loss pulse trails its enable, so that check waits three cycles
  a_zero_reload: assert property (
    ($changed(pos_r) && pos_r == 10'h000 && $stable(sin_r) && $stable(sin90_r))
      |-> (mag_r[0] == $signed({2'b00, sin_r}) && mag_r[1] == $signed({2'b00, sin90_r})))
    else $error("start values not reloaded at zero");
  a_walk_single: assert property (
    $changed(pos_r) |-> (pos_r == $past(pos_r) + 10'h001 || pos_r == $past(pos_r) - 10'h001))
    else $error("counter jumped more than one entry");
  a_walk_dir: assert property (
    (pend_r > 0 && !step_ev) |=> (pos_r == $past(pos_r) + 10'h001))
    else $error("counter did not advance");
  a_read_position: assert property (
    (i_psel && !i_penable && !i_pwrite && idx == MST_I_POS && i_paddr[1:0] == 2'b00)
      |=> o_prdata == {22'h000000, $past(pos_r)})
    else $error("position read back wrong");
  a_read_currents: assert property (
    (i_psel && !i_penable && idx == MST_I_CUR && i_paddr[1:0] == 2'b00)
      |=> o_prdata[8:0] == $past(cur_r[0]) && o_prdata[24:16] == $past(cur_r[1]))
    else $error("phase currents read back wrong");
  a_comm_limit: assert property (
    o_comm_limit_hit |-> $past(ontime_r) == {3'b000, $past(comm_r.commutation_on_limit)})
    else $error("commutation pulse at wrong on time");
  a_steploss_off: assert property (
    (comm_r.step_loss_on_limit == 8'h00) [*3] |-> !o_step_loss && !o_steploss_active)
    else $error("step loss active while disabled");
  a_steploss_high: assert property (
    (fshi_r && i_above_high_velocity_threshold && comm_r.step_loss_on_limit != 8'h00) |=> o_steploss_active)
    else $error("step loss off above high velocity");
  a_comm_enable: assert property (
    (den_f_r || i_above_commutation_velocity_threshold) |=> o_comm_active)
    else $error("commutation not enabled");
  a_duty_zero: assert property (
    (i_duty_cycle_actual == 8'h00) |=> o_coil_a_scaled == 9'h000 || o_coil_a_scaled == 9'h1ff)
    else $error("scaling ignores zero duty");
  a_unmapped_err: assert property (
    (acc && !mapped) |-> o_pslverr && o_pready)
    else $error("unmapped access not refused");

endmodule : mst_wave_regs

`default_nettype wire

/* File: dv/test_mst_wave_regs.sv */
/*
  Self-checking bench for the microstep wave generator and its register set.
  Assumes an APB slave that ends each access with pready, step pins seen late, no partner.
*/
`timescale 1ns/1ps
`default_nettype none

module test_mst_wave_regs;
  import mst_pkg::*;

  logic        i_mclk = 1'b0;  // Device clock
  logic        i_rst  = 1'b1;  // Reset, held at start
  logic        i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [11:0] i_paddr = '0;   // APB byte address
  logic [31:0] i_pwdata = '0;  // APB write data
  logic [31:0] o_prdata;       // APB read data
  logic        o_pready, o_pslverr;
  logic        i_step_pin = 1'b0, i_dir_pin = 1'b0, i_commutation_enable_pin = 1'b0;
  logic        i_above_commutation_velocity_threshold = 1'b0, i_above_high_velocity_threshold = 1'b0, i_pwm_on = 1'b0;
  logic [8:0]  o_phase_a_current, o_phase_b_current, o_coil_a_scaled, o_coil_b_scaled;
  logic        o_comm_active, o_steploss_active, o_comm_limit_hit, o_step_loss;
  logic [31:0] q;              // Last read word
  logic        e;              // Last error response
  logic [7:0]  duty = 8'hff;   // Regulator duty cycle fed to the block
  int          errors = 0, cmp_count = 0, cyc = 0, tc, ts;

  // 10 MHz clock
  always #50 i_mclk = ~i_mclk;

  mst_wave_regs u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_step_pin(i_step_pin), .i_dir_pin(i_dir_pin),
    .i_commutation_enable_pin(i_commutation_enable_pin), .i_above_commutation_velocity_threshold(i_above_commutation_velocity_threshold),
    .i_above_high_velocity_threshold(i_above_high_velocity_threshold), .i_pwm_on(i_pwm_on), .i_duty_cycle_actual(duty),
    .i_duty_offset(9'h1f3), .i_auto_offset(8'h3c), .i_auto_gradient_value(8'h5a),
    .i_driver_status(32'h1234_5678), .o_phase_a_current(o_phase_a_current),
    .o_phase_b_current(o_phase_b_current), .o_coil_a_scaled(o_coil_a_scaled),
    .o_coil_b_scaled(o_coil_b_scaled), .o_comm_active(o_comm_active),
    .o_steploss_active(o_steploss_active), .o_comm_limit_hit(o_comm_limit_hit),
    .o_step_loss(o_step_loss), .o_chopper_config(), .o_current_scaling_config(),
    .o_voltage_pwm_config());

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Verdict; also reached when the cycle ceiling runs out
  task automatic complete_run;
    $display("checks %0d, errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // Cut a hang short well above the expected run length
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc > 20000) begin
      errors++;
      complete_run();
    end
  end

  // One APB transfer: setup, then access held until pready is sampled high
  task automatic apb(input logic w, input logic [9:0] ix, input logic [31:0] d);
    @(posedge i_mclk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= {ix, 2'b00};
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    // Only the bench ceiling ends a wait that never sees pready
    do begin
      @(posedge i_mclk);
    end while (o_pready !== 1'b1);
    q = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  // One step pulse, long enough for the pin filter, then time for the walk
  task automatic step(input logic d);
    @(posedge i_mclk);
    i_dir_pin <= d;
    repeat (4) @(posedge i_mclk);
    i_step_pin <= 1'b1;
    repeat (4) @(posedge i_mclk);
    i_step_pin <= 1'b0;
    repeat (30) @(posedge i_mclk);
  endtask : step

  initial begin
    repeat (20) @(posedge i_mclk);
    i_rst <= 1'b0;
    // Reset state and plain register access
    apb(0, MST_I_CHOP, 0); chk(q, MST_RST_CHOP);
    apb(0, MST_I_CUR, 0); chk(q, 32'h00f7_0000);
    apb(1, MST_I_POS, 32'h3ff); apb(0, MST_I_POS, 0); chk(q, 0);
    apb(0, MST_I_TABLE0, 0); chk(q, 0);
    apb(0, MST_I_REGRES, 0); chk(q, 32'h01f3_00ff);
    apb(0, MST_I_AUTO, 0); chk(q, 32'h005a_003c);
    apb(0, MST_I_DSTAT, 0); chk(q, 32'h1234_5678);
    apb(1, MST_I_CHOP, 32'h0000_00a5); apb(0, MST_I_CHOP, 0); chk(q, 32'h0000_00a5);
    apb(1, 10'h005, 32'h1); chk({31'h0, e}, 32'h1); // Unmapped index is refused
    // Default sine: first step gives entry 1 on A, B holds its peak
    step(0); apb(0, MST_I_CUR, 0); chk(q, 32'h00f7_0001);
    step(1);
    // Reload of start values when the counter returns to zero
    apb(1, MST_I_TABLE0, 32'hffff_ffff);
    apb(1, MST_I_START, 32'h00c8_0005);
    apb(1, MST_I_SEGSEL, 32'hc080_40ff);
    step(0); step(1);
    apb(0, MST_I_CUR, 0); chk(q, 32'h00c8_0005);
    chk({23'h0, o_coil_a_scaled}, 32'h4);
    // Every width code with both bit values on the first entry
    for (int b = 0; b < 2; b++) begin
      for (int c = 0; c < 4; c++) begin
        apb(1, MST_I_TABLE0, {32{b[0]}});
        apb(1, MST_I_SEGSEL, {24'hc08040, {4{c[1:0]}}});
        step(0); apb(0, MST_I_CUR, 0);
        chk({23'h0, q[8:0]}, 32'(4 + b + c));
        step(1);
      end
    end
    // Segment border one entry in: first delta +3, second +0
    apb(1, MST_I_STEPCFG, 32'h1);
    apb(1, MST_I_SEGSEL, 32'hc080_0103);
    step(0); apb(0, MST_I_CUR, 0); chk({23'h0, q[8:0]}, 32'h8);
    step(1);
    // Resolution and wrap below zero
    apb(1, MST_I_STEPCFG, 32'h2);
    step(0); apb(0, MST_I_POS, 0); chk(q, 32'h4);
    step(1); step(1); apb(0, MST_I_POS, 0); chk(q, 32'h3fc);
    // Commutation limits timed from the start of the on phase
    apb(1, MST_I_COMM, 32'h0001_0005);
    i_above_commutation_velocity_threshold <= 1'b1;
    repeat (3) @(posedge i_mclk);
    chk({31'h0, o_comm_active}, 32'h1);
    tc = 0; ts = 0;
    i_pwm_on <= 1'b1;
    for (int n = 1; n < 40; n++) begin
      @(posedge i_mclk); #1;
      if (o_comm_limit_hit === 1'b1) tc = n;
      if (o_step_loss === 1'b1) ts = n;
    end
    // Back on a rising edge before inputs change
    @(posedge i_mclk);
    chk(32'(tc), 32'd6);
    chk(32'(ts), 32'd17);
    i_pwm_on <= 1'b0;
    i_above_commutation_velocity_threshold <= 1'b0;
    i_commutation_enable_pin <= 1'b1;
    repeat (8) @(posedge i_mclk);
    chk({31'h0, o_comm_active}, 32'h1);
    i_commutation_enable_pin <= 1'b0;
    apb(1, MST_I_STEPCFG, 32'h100); i_above_high_velocity_threshold <= 1'b1;
    repeat (8) @(posedge i_mclk);
    chk({31'h0, o_steploss_active}, 32'h1);
    apb(1, MST_I_COMM, 32'h0000_0005); repeat (3) @(posedge i_mclk);
    chk({31'h0, o_steploss_active}, 32'h0);
    // Phase A sits at -8 here: full duty keeps it, zero duty removes it
    chk({23'h0, o_coil_a_scaled}, 32'h1f8);
    duty <= 8'h00;
    repeat (3) @(posedge i_mclk);
    chk({23'h0, o_coil_a_scaled}, 32'h0);
    complete_run();
  end

endmodule : test_mst_wave_regs

`default_nettype wire
